// file: hdl/pps_defines.svh
// Contract
// - Serial mode sends frame bits as NRZ data on one transmit data pin.
// - Serial carrier, collision and receive data ignored while nibble port selected.
// - Encoder supplies 10 MHz transmit clock; serial sending timed from it only.
// - Encoder supplies recovered 10 MHz receive clock; used only for serial reception.
// - Loopback pin follows transmit control bit 1 regardless of port.
// - Active-low link input shows as link status bit 14, any port.
// - Full-step pin low is inverse of configuration bit 10, held level.
// - Port select pin follows configuration bit 15; high means nibble port.
// - Attachment-unit select pin follows configuration bit 8, any port.
// - Fast transmit enable envelopes nibble sends; low while serial port selected.
// - Nibble carrier sense drives deferral; ignored while serial port selected.
// - Receive data valid frames nibble reception; ignored while serial port selected.
// - Nibble collision input is the collision signal; ignored in serial mode.
// - Outgoing data leaves one nibble at a time on four data pins.
// - PHY supplies nibble transmit clock; nibble sending timed from it only.
// - PHY supplies nibble receive clock; nibbles sampled on it only.
// - Received nibbles taken from four data pins; ignored in serial mode.
// - Management traffic uses separate data output and data input pins.
// - Serial transmit enable stays low while nibble port is selected.
// - Receive code error discards frame as bad CRC; ignored in serial mode.
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

`define PPS_ADDR_W 8
`define PPS_OFS_CONFIG 8'h00
`define PPS_OFS_TX_CTRL 8'h04
`define PPS_OFS_PHY_STATUS 8'h08
`define PPS_OFS_RX_STATUS 8'h0C
`define PPS_OFS_MGMT 8'h10

`define PPS_CFG_PORT_SEL 15
`define PPS_CFG_FULL_STEP 10
`define PPS_CFG_ATTACH_SEL 8
`define PPS_TCR_LOOP 1
`define PPS_PHY_LINK 14
`define PPS_RXS_BAD_CRC 13
`define PPS_MGMT_OUT 0
`define PPS_MGMT_IN 1

`define PPS_RST_CONFIG 16'h0000
`define PPS_RST_TX_CTRL 16'h0000
`define PPS_RST_MGMT 16'h0000
`define PPS_RST_SYNC 17'h0063C

`define PPS_SYNC_W 17
`define PPS_SER_LAST 2'h3

`endif

// file: hdl/pps_pkg.sv
package pps_pkg;

  typedef enum logic {
    PPS_TX_IDLE,
    PPS_TX_SEND
  } pps_tx_state_e;

  typedef logic [15:0] pps_reg_t;

endpackage : pps_pkg

// file: hdl/pps_port_select.sv
`timescale 1ns/10ps
`include "pps_defines.svh"

module pps_port_select (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Register port
  input wire logic [`PPS_ADDR_W-1:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // Transmit nibble stream from the MAC
  input wire logic tx_valid_in,
  input wire logic [3:0] tx_nibble_in,
  input wire logic tx_last_in,
  output logic tx_ready_out,
  // Receive nibble stream to the MAC
  output logic rx_valid_out,
  output logic [3:0] rx_nibble_out,
  output logic rx_end_out,
  output logic rx_bad_out,
  // Medium state toward the MAC
  output logic carrier_out,
  output logic collision_out,
  // Serial encoder port
  output logic endec_tx_data_out,
  output logic endec_tx_enable_out,
  input wire logic endec_carrier_sense_in,
  input wire logic endec_collision_in,
  input wire logic endec_rx_data_in,
  input wire logic endec_tx_clock_in,
  input wire logic endec_rx_clock_in,
  // Straps and status pins
  output logic loopback_out,
  input wire logic link_status_in_n,
  output logic full_step_out_n,
  output logic nibble_port_select_out,
  output logic attach_unit_select_out,
  // Nibble port
  output logic fast_tx_enable_out,
  output logic [3:0] nibble_tx_data_out,
  input wire logic fast_carrier_sense_in,
  input wire logic fast_rx_valid_in,
  input wire logic fast_rx_error_in,
  input wire logic fast_collision_in,
  input wire logic nibble_tx_clock_in,
  input wire logic nibble_rx_clock_in,
  input wire logic [3:0] nibble_rx_data_in,
  // Management data pair
  output logic mgmt_data_out,
  input wire logic mgmt_data_in
);

  pps_pkg::pps_reg_t config_r;
  pps_pkg::pps_reg_t tx_ctrl_r;
  pps_pkg::pps_reg_t mgmt_r;
  logic bad_crc_r;
  logic [15:0] rdata_r;

  logic [`PPS_SYNC_W-1:0] raw_pins;
  logic [`PPS_SYNC_W-1:0] meta_r;
  logic [`PPS_SYNC_W-1:0] sync_r;
  logic [3:0] clk_prev_r;

  logic sel;
  logic sel_prev_r;
  logic s_endec_crs, s_endec_col, s_endec_rxd, s_endec_txc, s_endec_rxc;
  logic s_link_n, s_fast_crs, s_fast_dv, s_fast_col, s_nib_txc, s_nib_rxc;
  logic s_fast_er, s_mdi;
  logic [3:0] s_nib_rxd;
  logic endec_txc_rise, endec_rxc_rise, nib_txc_rise, nib_rxc_rise;

  pps_pkg::pps_tx_state_e tx_state_r;
  logic tx_last_r;
  logic [3:0] tx_shift_r;
  logic [1:0] tx_bit_r;
  logic endec_txd_r;
  logic endec_en_r;
  logic fast_en_r;
  logic [3:0] nib_txd_r;
  logic tx_edge, tx_slot, tx_take;

  logic rx_edge, rx_frame;
  logic rx_active_r;
  logic rx_err_r;
  logic [3:0] rx_shift_r;
  logic [1:0] rx_bit_r;
  logic rx_valid_r;
  logic [3:0] rx_nibble_r;
  logic rx_end_r;
  logic rx_bad_r;
  logic carrier_r;
  logic collision_r;

  function automatic logic hit(input logic [`PPS_ADDR_W-1:0] a,
                               input logic [`PPS_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Every pin from the link side passes two flops before use
  assign raw_pins = {nibble_rx_data_in, mgmt_data_in, fast_rx_error_in,
                     nibble_rx_clock_in, nibble_tx_clock_in,
                     fast_collision_in, fast_rx_valid_in,
                     fast_carrier_sense_in, link_status_in_n,
                     endec_rx_clock_in, endec_tx_clock_in,
                     endec_rx_data_in, endec_collision_in,
                     endec_carrier_sense_in};

  // Start at the pulled-up idle levels so no false clock edge follows reset
  localparam logic [`PPS_SYNC_W-1:0] sync_idle = `PPS_RST_SYNC;
  genvar g;
  generate
    for (g = 0; g < `PPS_SYNC_W; g = g + 1) begin : g_sync
      always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
          meta_r[g] <= sync_idle[g];
          sync_r[g] <= sync_idle[g];
        end else begin
          meta_r[g] <= raw_pins[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign s_endec_crs = sync_r[0];
  assign s_endec_col = sync_r[1];
  assign s_endec_rxd = sync_r[2];
  assign s_endec_txc = sync_r[3];
  assign s_endec_rxc = sync_r[4];
  assign s_link_n = sync_r[5];
  assign s_fast_crs = sync_r[6];
  assign s_fast_dv = sync_r[7];
  assign s_fast_col = sync_r[8];
  assign s_nib_txc = sync_r[9];
  assign s_nib_rxc = sync_r[10];
  assign s_fast_er = sync_r[11];
  assign s_mdi = sync_r[12];
  assign s_nib_rxd = sync_r[16:13];

  // Edge finders on the resynchronised link clocks
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      clk_prev_r <= 4'hF;
      sel_prev_r <= 1'b0;
    end else begin
      clk_prev_r <= {s_nib_rxc, s_nib_txc, s_endec_rxc, s_endec_txc};
      sel_prev_r <= sel;
    end
  end

  assign sel = config_r[`PPS_CFG_PORT_SEL];
  // Each clock only counts while its own port is selected
  assign endec_txc_rise = !sel && s_endec_txc && !clk_prev_r[0];
  assign endec_rxc_rise = !sel && s_endec_rxc && !clk_prev_r[1];
  assign nib_txc_rise = sel && s_nib_txc && !clk_prev_r[2];
  assign nib_rxc_rise = sel && s_nib_rxc && !clk_prev_r[3];

  // Register writes
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      config_r <= `PPS_RST_CONFIG;
      tx_ctrl_r <= `PPS_RST_TX_CTRL;
      mgmt_r <= `PPS_RST_MGMT;
    end else if (reg_wr_in) begin
      if (hit(reg_addr_in, `PPS_OFS_CONFIG)) begin
        config_r <= reg_wdata_in;
      end
      if (hit(reg_addr_in, `PPS_OFS_TX_CTRL)) begin
        tx_ctrl_r <= reg_wdata_in;
      end
      if (hit(reg_addr_in, `PPS_OFS_MGMT)) begin
        mgmt_r <= reg_wdata_in;
      end
    end
  end

  // Bad-frame flag: write one to clear, a new error wins over the clear
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      bad_crc_r <= 1'b0;
    end else if (rx_end_r && rx_bad_r) begin
      bad_crc_r <= 1'b1;
    end else if (reg_wr_in && hit(reg_addr_in, `PPS_OFS_RX_STATUS) &&
                 reg_wdata_in[`PPS_RXS_BAD_CRC]) begin
      bad_crc_r <= 1'b0;
    end
  end

  // Register reads, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd_in) begin
      rdata_r <= 16'h0000;
      if (hit(reg_addr_in, `PPS_OFS_CONFIG)) begin
        rdata_r <= config_r;
      end
      if (hit(reg_addr_in, `PPS_OFS_TX_CTRL)) begin
        rdata_r <= tx_ctrl_r;
      end
      if (hit(reg_addr_in, `PPS_OFS_PHY_STATUS)) begin
        rdata_r[`PPS_PHY_LINK] <= !s_link_n;
      end
      if (hit(reg_addr_in, `PPS_OFS_RX_STATUS)) begin
        rdata_r[`PPS_RXS_BAD_CRC] <= bad_crc_r;
      end
      if (hit(reg_addr_in, `PPS_OFS_MGMT)) begin
        rdata_r[`PPS_MGMT_OUT] <= mgmt_r[`PPS_MGMT_OUT];
        rdata_r[`PPS_MGMT_IN] <= s_mdi;
      end
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign reg_rdata_out = rdata_r;

  // Pins driven straight from control bits
  assign loopback_out = tx_ctrl_r[`PPS_TCR_LOOP];
  assign full_step_out_n = !config_r[`PPS_CFG_FULL_STEP];
  assign nibble_port_select_out = config_r[`PPS_CFG_PORT_SEL];
  assign attach_unit_select_out = config_r[`PPS_CFG_ATTACH_SEL];
  assign mgmt_data_out = mgmt_r[`PPS_MGMT_OUT];

  // Transmit: a slot opens on each nibble clock edge, or every fourth
  // serial clock edge once the shifter has emptied
  assign tx_edge = sel ? nib_txc_rise : endec_txc_rise;
  assign tx_slot = tx_edge &&
                   (sel || tx_state_r == pps_pkg::PPS_TX_IDLE ||
                    tx_bit_r == `PPS_SER_LAST);
  assign tx_take = tx_slot &&
                   !(tx_state_r == pps_pkg::PPS_TX_SEND && tx_last_r);
  assign tx_ready_out = tx_take;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      tx_state_r <= pps_pkg::PPS_TX_IDLE;
      tx_last_r <= 1'b0;
    // A port change abandons the frame in flight
    end else if (sel != sel_prev_r || tx_slot) begin
      if (tx_take && tx_valid_in) begin
        tx_state_r <= pps_pkg::PPS_TX_SEND;
        tx_last_r <= tx_last_in;
      end else begin
        tx_state_r <= pps_pkg::PPS_TX_IDLE;
        tx_last_r <= 1'b0;
      end
    end
  end

  // Nibble port transmit path
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      fast_en_r <= 1'b0;
      nib_txd_r <= 4'h0;
    end else if (!sel) begin
      fast_en_r <= 1'b0;
    end else if (tx_slot) begin
      fast_en_r <= tx_take && tx_valid_in;
      if (tx_take && tx_valid_in) begin
        nib_txd_r <= tx_nibble_in;
      end
    end
  end

  assign fast_tx_enable_out = fast_en_r;
  assign nibble_tx_data_out = nib_txd_r;

  // Serial transmit path, bit 0 of each nibble first
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      endec_en_r <= 1'b0;
      endec_txd_r <= 1'b0;
      tx_shift_r <= 4'h0;
      tx_bit_r <= 2'h0;
    end else if (sel) begin
      endec_en_r <= 1'b0;
      endec_txd_r <= 1'b0;
      tx_bit_r <= 2'h0;
    end else if (tx_slot) begin
      tx_bit_r <= 2'h0;
      endec_en_r <= tx_take && tx_valid_in;
      if (tx_take && tx_valid_in) begin
        tx_shift_r <= {1'b0, tx_nibble_in[3:1]};
        endec_txd_r <= tx_nibble_in[0];
      end else begin
        endec_txd_r <= 1'b0;
      end
    end else if (endec_txc_rise && tx_state_r == pps_pkg::PPS_TX_SEND) begin
      endec_txd_r <= tx_shift_r[0];
      tx_shift_r <= {1'b0, tx_shift_r[3:1]};
      tx_bit_r <= tx_bit_r + 2'h1;
    end
  end

  assign endec_tx_data_out = endec_txd_r;
  assign endec_tx_enable_out = endec_en_r;

  // Receive: the unselected port's inputs never reach the frame logic
  assign rx_edge = sel ? nib_rxc_rise : endec_rxc_rise;
  assign rx_frame = sel ? s_fast_dv : s_endec_crs;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rx_active_r <= 1'b0;
      rx_err_r <= 1'b0;
      rx_shift_r <= 4'h0;
      rx_bit_r <= 2'h0;
      rx_valid_r <= 1'b0;
      rx_nibble_r <= 4'h0;
      rx_end_r <= 1'b0;
      rx_bad_r <= 1'b0;
    end else begin
      rx_valid_r <= 1'b0;
      rx_end_r <= 1'b0;
      if (rx_edge && rx_frame) begin
        rx_active_r <= 1'b1;
        if (sel) begin
          rx_nibble_r <= s_nib_rxd;
          rx_valid_r <= 1'b1;
          if (s_fast_er) begin
            rx_err_r <= 1'b1;
          end
        end else begin
          rx_shift_r <= {s_endec_rxd, rx_shift_r[3:1]};
          rx_bit_r <= rx_bit_r + 2'h1;
          if (rx_bit_r == `PPS_SER_LAST) begin
            rx_nibble_r <= {s_endec_rxd, rx_shift_r[3:1]};
            rx_valid_r <= 1'b1;
          end
        end
      end else if (rx_edge && rx_active_r) begin
        // Frame closes on the first clock edge without its envelope
        rx_active_r <= 1'b0;
        rx_end_r <= 1'b1;
        rx_bad_r <= rx_err_r;
        rx_err_r <= 1'b0;
        rx_bit_r <= 2'h0;
      end
    end
  end

  assign rx_valid_out = rx_valid_r;
  assign rx_nibble_out = rx_nibble_r;
  assign rx_end_out = rx_end_r;
  assign rx_bad_out = rx_bad_r;

  // Medium state for deferral, backoff and collision handling
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      carrier_r <= 1'b0;
      collision_r <= 1'b0;
    end else begin
      carrier_r <= sel ? s_fast_crs : s_endec_crs;
      collision_r <= sel ? s_fast_col : s_endec_col;
    end
  end

  assign carrier_out = carrier_r;
  assign collision_out = collision_r;

endmodule : pps_port_select

// file: tb/pps_port_select_props.sv
`timescale 1ns/10ps
module pps_port_select_props (
  // Clock, reset and register port
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  // Pins
  input wire logic tx_valid_in,
  input wire logic tx_ready_out,
  input wire logic link_status_in_n,
  input wire logic loopback_out,
  input wire logic full_step_out_n,
  input wire logic nibble_port_select_out,
  input wire logic attach_unit_select_out,
  input wire logic endec_tx_enable_out,
  input wire logic fast_tx_enable_out,
  input wire logic mgmt_data_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  logic cfg_wr;
  assign cfg_wr = reg_wr_in && reg_addr_in == 8'h00;
  a_sel_follows: assert property (
    cfg_wr |=> nibble_port_select_out == $past(reg_wdata_in[15]))
    else $error("port select pin wrong");
  a_step_inverse: assert property (
    cfg_wr |=> full_step_out_n != $past(reg_wdata_in[10]))
    else $error("full step pin wrong");
  a_attach_sel: assert property (
    cfg_wr |=> attach_unit_select_out == $past(reg_wdata_in[8]))
    else $error("attach select pin wrong");
  a_loop_bit: assert property (
    reg_wr_in && reg_addr_in == 8'h04 |=>
    loopback_out == $past(reg_wdata_in[1]))
    else $error("loopback pin wrong");
  a_mgmt_drive: assert property (
    reg_wr_in && reg_addr_in == 8'h10 |=>
    mgmt_data_out == $past(reg_wdata_in[0]))
    else $error("management out pin wrong");
  // One cycle of grace: enable clears one edge after select changes
  a_serial_quiet: assert property (
    nibble_port_select_out && $past(nibble_port_select_out) |->
    !endec_tx_enable_out)
    else $error("serial enable in nibble mode");
  a_fast_quiet: assert property (
    !nibble_port_select_out && !$past(nibble_port_select_out) |->
    !fast_tx_enable_out)
    else $error("fast enable in serial mode");
  a_tx_taken: assert property (
    $rose(fast_tx_enable_out) |-> $past(tx_ready_out && tx_valid_in))
    else $error("fast enable without a taken nibble");
  // Link pin must be steady past the synchroniser before the read
  a_link_read: assert property (
    $stable(link_status_in_n) [*4] ##0
    (reg_rd_in && reg_addr_in == 8'h08) |=>
    reg_rdata_out[14] != $past(link_status_in_n))
    else $error("link status bit wrong");
  c_fast_tx: cover property (fast_tx_enable_out);
  c_serial_tx: cover property (endec_tx_enable_out);
  c_nibble_sel: cover property (cfg_wr ##1 nibble_port_select_out);
endmodule : pps_port_select_props

bind pps_port_select pps_port_select_props pps_port_select_props_inst (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out),
  .link_status_in_n(link_status_in_n), .loopback_out(loopback_out),
  .full_step_out_n(full_step_out_n),
  .nibble_port_select_out(nibble_port_select_out),
  .attach_unit_select_out(attach_unit_select_out),
  .endec_tx_enable_out(endec_tx_enable_out),
  .fast_tx_enable_out(fast_tx_enable_out),
  .mgmt_data_out(mgmt_data_out)
);

// file: tb/pps_phy_model.sv
`timescale 1ns/10ps
module pps_phy_model (
  // Transmit side from the device
  input wire logic fast_tx_enable_in,
  input wire logic [3:0] nibble_tx_data_in,
  input wire logic endec_tx_enable_in,
  input wire logic endec_tx_data_in,
  // Link clock and receive side
  output logic link_clock_out,
  output logic rx_valid_out,
  output logic rx_error_out,
  output logic [3:0] rx_data_out
);
  logic [4:0] rx_q[$];
  logic [3:0] tx_q[$];
  initial begin
    link_clock_out = 1'b1;
    rx_valid_out = 1'b0;
    rx_error_out = 1'b0;
    rx_data_out = 4'h0;
  end
  // Clock stands at its pull-up level between runs
  task automatic run(input int n);
    #7;
    repeat (n) begin
      #160 link_clock_out = 1'b0;
      if (fast_tx_enable_in) tx_q.push_back(nibble_tx_data_in);
      if (endec_tx_enable_in) tx_q.push_back({3'h0, endec_tx_data_in});
      if (rx_q.size() > 0) begin
        {rx_error_out, rx_data_out} = rx_q.pop_front();
        rx_valid_out = 1'b1;
      end else begin
        rx_valid_out = 1'b0;
        rx_error_out = 1'b0;
        // Undriven data lines keep moving so stale values never match
        rx_data_out = ~rx_data_out;
      end
      #160 link_clock_out = 1'b1;
    end
  endtask : run
endmodule : pps_phy_model

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic tx_valid_in = 1'b0;
  logic [3:0] tx_nibble_in = 4'h0;
  logic tx_last_in = 1'b0;
  logic link_status_in_n = 1'b1;
  logic mgmt_data_in = 1'b0;
  logic [15:0] reg_rdata_out, d;
  logic [3:0] rx_nibble_out, nibble_tx_data_out, rxd, pins;
  logic tx_ready_out, rx_valid_out, rx_end_out, rx_bad_out, lclk, dv, er;
  logic endec_tx_data_out, endec_tx_enable_out, fast_tx_enable_out;
  logic loopback_out, full_step_out_n, nibble_port_select_out;
  logic attach_unit_select_out, mgmt_data_out, carrier_out, collision_out;
  logic bad_seen = 1'b0;
  logic [1:0] seen = 2'h0;
  logic [3:0] got_q[$];
  logic [15:0] cfg[4] = '{16'h8500, 16'h8000, 16'h0400, 16'h0100};
  int miscompares = 0;
  int total_checks = 0;
  always #20 clk_in = ~clk_in;
  pps_port_select pps_port_select_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .tx_valid_in(tx_valid_in), .tx_nibble_in(tx_nibble_in),
    .tx_last_in(tx_last_in), .tx_ready_out(tx_ready_out),
    .rx_valid_out(rx_valid_out), .rx_nibble_out(rx_nibble_out),
    .rx_end_out(rx_end_out), .rx_bad_out(rx_bad_out),
    .carrier_out(carrier_out), .collision_out(collision_out),
    .endec_tx_data_out(endec_tx_data_out),
    .endec_tx_enable_out(endec_tx_enable_out),
    .endec_carrier_sense_in(dv), .endec_collision_in(1'b0),
    .endec_rx_data_in(rxd[0]), .endec_tx_clock_in(lclk),
    .endec_rx_clock_in(lclk), .loopback_out(loopback_out),
    .link_status_in_n(link_status_in_n), .full_step_out_n(full_step_out_n),
    .nibble_port_select_out(nibble_port_select_out),
    .attach_unit_select_out(attach_unit_select_out),
    .fast_tx_enable_out(fast_tx_enable_out),
    .nibble_tx_data_out(nibble_tx_data_out), .fast_carrier_sense_in(dv),
    .fast_rx_valid_in(dv), .fast_rx_error_in(er), .fast_collision_in(er),
    .nibble_tx_clock_in(lclk), .nibble_rx_clock_in(lclk),
    .nibble_rx_data_in(rxd), .mgmt_data_out(mgmt_data_out),
    .mgmt_data_in(mgmt_data_in)
  );
  pps_phy_model phy (
    .fast_tx_enable_in(fast_tx_enable_out),
    .nibble_tx_data_in(nibble_tx_data_out),
    .endec_tx_enable_in(endec_tx_enable_out),
    .endec_tx_data_in(endec_tx_data_out), .link_clock_out(lclk),
    .rx_valid_out(dv), .rx_error_out(er), .rx_data_out(rxd)
  );
  always @(posedge clk_in) begin
    if (rx_valid_out) got_q.push_back(rx_nibble_out);
    if (rx_end_out) bad_seen <= rx_bad_out;
    seen <= seen | {collision_out, carrier_out};
  end
  task automatic wrap_up();
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string s, input logic [15:0] e, g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic chkq(input string s, ref logic [3:0] q[$],
                      input logic [15:0] e, input int n);
    chk(s, 16'(n), 16'(q.size()));
    for (int k = 0; k < n && k < q.size(); k++) chk(s, e[4*k+:4], q[k]);
  endtask : chkq
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  // Read data are taken mid-cycle, inside their only valid cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    v = reg_rdata_out;
    @(posedge clk_in);
  endtask : rd
  task automatic send(input logic [11:0] v, input int n);
    int t;
    for (int k = 0; k < n; k++) begin
      tx_valid_in <= 1'b1;
      tx_nibble_in <= v[4*k+:4];
      tx_last_in <= (k == n - 1);
      t = 0;
      do begin
        @(negedge clk_in);
        t++;
      end while (tx_ready_out !== 1'b1 && t < 400);
      if (t >= 400) begin
        miscompares++;
        wrap_up();
      end
      @(posedge clk_in);
    end
    tx_valid_in <= 1'b0;
    tx_last_in <= 1'b0;
  endtask : send
  initial begin
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    pins = {nibble_port_select_out, full_step_out_n, attach_unit_select_out,
            loopback_out};
    chk("reset pins", 16'h0004, {12'h0, pins});
    foreach (cfg[i]) begin
      wr(8'h00, cfg[i]);
      wr(8'h04, {14'h0, cfg[i][8], 1'b0});
      rd(8'h00, d);
      chk("config", cfg[i] & 16'h8500, d & 16'h8500);
      pins = {nibble_port_select_out, full_step_out_n,
              attach_unit_select_out, loopback_out};
      d = {12'h0, cfg[i][15], ~cfg[i][10], cfg[i][8], cfg[i][8]};
      chk("pins", d, {12'h0, pins});
    end
    for (int l = 0; l < 2; l++) begin
      link_status_in_n <= l[0];
      repeat (5) @(posedge clk_in);
      rd(8'h08, d);
      chk("link", {1'b0, ~l[0], 14'h0}, d & 16'h4000);
    end
    wr(8'h10, 16'h0001);
    mgmt_data_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd(8'h10, d);
    chk("mgmt", 16'h0003, d & 16'h0003);
    rd(8'h3C, d);
    chk("unmapped", 16'h0000, d);
    for (int m = 0; m < 2; m++) begin
      wr(8'h00, {m[0], 15'h0});
      phy.tx_q.delete();
      fork
        phy.run(7);
        send(m ? 12'hFA5 : 12'h006, m ? 3 : 1);
      join
      chkq("tx", phy.tx_q, m ? 16'h0FA5 : 16'h0110, m ? 3 : 4);
    end
    for (int m = 0; m < 2; m++) begin
      wr(8'h00, {m[0], 15'h0});
      got_q.delete();
      phy.rx_q = '{5'h03, 5'h1C, 5'h09, 5'h0E};
      phy.run(6);
      repeat (4) @(posedge clk_in);
      chkq("rx", got_q, m ? 16'hE9C3 : 16'h0005, m ? 4 : 1);
      chk("medium", m ? 16'h0003 : 16'h0001, {14'h0, seen});
    end
    chk("bad", 16'h0001, {15'h0, bad_seen});
    rd(8'h0C, d);
    chk("rx status", 16'h2000, d & 16'h2000);
    wr(8'h0C, 16'h2000);
    rd(8'h0C, d);
    chk("rx status", 16'h0000, d & 16'h2000);
    wrap_up();
  end
endmodule : tb
